// [hdl/dspd_regs.vh]
// Purpose: Constants for the DRAM space pin driver
// Assumes: 20 MHz core_clk, synchronous active-high reset
// Notes:   Encodings of bus width, access size and sequencer timing
// Functional notes
// R1: Row strobe is active during every DRAM space access, any width or size.
// R2: 8/16-bit space: byte0 strobe for 8-bit/lower/word, byte1 for upper/word.
// R3: 8/16-bit space: upper data on lane1, lower on lane0; others high-Z.
// R4: 32-bit space: one column strobe per byte lane; pairs or all four for words.
// R5: 32-bit space: MSB on lane3 down to LSB on lane0; only accessed lanes driven.
// R6: All four area selects stay high during DRAM space accesses.
// R7: Direction output high for reads, low for writes.
// R8: Address latch strobe held low throughout DRAM accesses.
// R9: Read strobe low on reads, high on writes.
// R10: 32-bit writes pull write strobe of each accessed lane low; none on reads.
// R11: Row strobe also asserted in row-held mode and during refresh.
// R12: All column strobes asserted during refresh.
// R13: Row strobe precedes column strobes on accesses (asserted together during refresh); column strobes release no later.
`ifndef DSPD_REGS_VH
`define DSPD_REGS_VH
// Bus width of the DRAM space
`define DSPD_W8        2'h0
`define DSPD_W16       2'h1
`define DSPD_W32       2'h2
// Access size
`define DSPD_SZ_BYTE   2'h0
`define DSPD_SZ_WORD   2'h1
`define DSPD_SZ_LONG   2'h2
// Sequencer states
`define DSPD_ST_IDLE   3'h0
`define DSPD_ST_ROW    3'h1
`define DSPD_ST_COL    3'h2
`define DSPD_ST_END    3'h3
`define DSPD_ST_REF    3'h4
// Timing: row-to-column and column hold time in ns, and cycle counts
`define DSPD_CLK_NS    50
`define DSPD_T_RCD_NS  50
`define DSPD_T_CAS_NS  100
`define DSPD_RCD_CYC   ((`DSPD_T_RCD_NS + `DSPD_CLK_NS - 1) / `DSPD_CLK_NS)
`define DSPD_CAS_CYC   ((`DSPD_T_CAS_NS + `DSPD_CLK_NS - 1) / `DSPD_CLK_NS)
`define DSPD_CNT_W     3
// Idle pin levels
`define DSPD_RST_STROBES 4'hF
`endif

// [hdl/dspd_lane_decode.v]
// Purpose: Decode DRAM bus width, size and address into active byte lanes
// Assumes: Address low bits are the byte offset; big-endian lane order
// Notes:   Lane 3 carries the most significant byte
`timescale 1ns/1ns
`include "dspd_regs.vh"
module dspd_lane_decode (
  width,
  size,
  addr_lo,
  lanes
);
  input  wire [1:0] width;
  input  wire [1:0] size;
  input  wire [1:0] addr_lo;
  output reg  [3:0] lanes;

  always @* begin
    lanes = 4'h0;
    case (width)
      `DSPD_W8: begin
        lanes = 4'h1; // R2 R3
      end
      `DSPD_W16: begin
        if (size == `DSPD_SZ_BYTE) begin
          lanes = addr_lo[0] ? 4'h1 : 4'h2; // R2 R3
        end else begin
          lanes = 4'h3; // R2 R3
        end
      end
      `DSPD_W32: begin
        case (size)
          `DSPD_SZ_BYTE: lanes = 4'h8 >> addr_lo; // R4 R5
          `DSPD_SZ_WORD: lanes = addr_lo[1] ? 4'h3 : 4'hC; // R4 R5
          default:       lanes = 4'hF; // R4 R5
        endcase
      end
      default: begin
        lanes = 4'h0;
      end
    endcase
  end
endmodule // dspd_lane_decode

// [hdl/dspd_pin_driver.v]
// Purpose: Drive external bus pins for accesses to DRAM space
// Assumes: Request fields are sampled only in the cycle where req_valid and req_ready are both high
// Notes:   Data pins are split into in/out/enable per lane
`timescale 1ns/1ns
`include "dspd_regs.vh"
module dspd_pin_driver (
  core_clk,
  rst,
  clk_en,
  req_valid,
  req_ready,
  req_write,
  req_width,
  req_size,
  req_addr,
  req_wdata,
  refresh_req,
  row_held,
  rsp_valid,
  rsp_rdata,
  area_select_n,
  row_strobe_n,
  col_strobe_byte3_n,
  col_strobe_byte2_n,
  col_strobe_byte1_n,
  col_strobe_byte0_n,
  read_write,
  address_latch_strobe_n,
  read_strobe_n,
  write_strobe_byte3_n,
  write_strobe_byte2_n,
  write_strobe_byte1_n,
  write_strobe_byte0_n,
  address_bus,
  data_in,
  data_out,
  data_oe
);
  input  wire        core_clk;
  input  wire        rst;
  input  wire        clk_en;
  input  wire        req_valid;
  output wire        req_ready;
  input  wire        req_write;
  input  wire [1:0]  req_width;
  input  wire [1:0]  req_size;
  input  wire [21:0] req_addr;
  input  wire [31:0] req_wdata;
  input  wire        refresh_req;
  input  wire        row_held;
  output reg         rsp_valid;
  output reg  [31:0] rsp_rdata;
  output reg  [3:0]  area_select_n;
  output reg         row_strobe_n;
  output reg         col_strobe_byte3_n;
  output reg         col_strobe_byte2_n;
  output reg         col_strobe_byte1_n;
  output reg         col_strobe_byte0_n;
  output reg         read_write;
  output reg         address_latch_strobe_n;
  output reg         read_strobe_n;
  output reg         write_strobe_byte3_n;
  output reg         write_strobe_byte2_n;
  output reg         write_strobe_byte1_n;
  output reg         write_strobe_byte0_n;
  output reg  [21:0] address_bus;
  input  wire [31:0] data_in;
  output reg  [31:0] data_out;
  output reg  [3:0]  data_oe;

  reg  [2:0]                state_r;
  reg  [2:0]                state_nxt;
  reg  [`DSPD_CNT_W-1:0]    cnt_r;
  reg  [3:0]                lanes_r;
  reg                       write_r;
  reg                       width32_r;
  wire [3:0]                lanes_dec;
  reg  [3:0]                cas_n;
  reg  [3:0]                wr_n;
  reg                       ras_n;

  // Counter reload values, cut to the counter width where they are used
  localparam [31:0] RCD_LD = `DSPD_RCD_CYC - 1;
  localparam [31:0] CAS_LD = `DSPD_CAS_CYC - 1;

  dspd_lane_decode u_dec (
    .width   (req_width),
    .size    (req_size),
    .addr_lo (req_addr[1:0]),
    .lanes   (lanes_dec)
  );

  assign req_ready = (state_r == `DSPD_ST_IDLE) && !refresh_req;

  // ===========================================================
  // Sequencer
  // ===========================================================
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `DSPD_ST_IDLE: begin
        if (refresh_req) begin
          state_nxt = `DSPD_ST_REF;
        end else if (req_valid) begin
          state_nxt = `DSPD_ST_ROW;
        end
      end
      `DSPD_ST_ROW: begin
        if (cnt_r == {`DSPD_CNT_W{1'b0}}) begin
          state_nxt = `DSPD_ST_COL;
        end
      end
      `DSPD_ST_COL: begin
        if (cnt_r == {`DSPD_CNT_W{1'b0}}) begin
          state_nxt = `DSPD_ST_END;
        end
      end
      `DSPD_ST_END: begin
        state_nxt = `DSPD_ST_IDLE;
      end
      `DSPD_ST_REF: begin
        if (cnt_r == {`DSPD_CNT_W{1'b0}}) begin
          state_nxt = `DSPD_ST_IDLE;
        end
      end
      default: begin
        state_nxt = `DSPD_ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      state_r   <= `DSPD_ST_IDLE;
      cnt_r     <= {`DSPD_CNT_W{1'b0}};
      lanes_r   <= 4'h0;
      write_r   <= 1'b0;
      width32_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      if (state_r == `DSPD_ST_IDLE && state_nxt == `DSPD_ST_ROW) begin
        lanes_r   <= lanes_dec;
        write_r   <= req_write;
        width32_r <= (req_width == `DSPD_W32);
      end
      if (state_nxt != state_r) begin
        if (state_nxt == `DSPD_ST_ROW) begin
          cnt_r <= RCD_LD[`DSPD_CNT_W-1:0];
        end else begin
          cnt_r <= CAS_LD[`DSPD_CNT_W-1:0];
        end
      end else if (cnt_r != {`DSPD_CNT_W{1'b0}}) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // ===========================================================
  // Pin levels
  // ===========================================================
  always @* begin
    ras_n = 1'b1;
    cas_n = 4'hF;
    wr_n  = 4'hF;
    if (state_r == `DSPD_ST_ROW || state_r == `DSPD_ST_COL) begin
      ras_n = 1'b0; // R1 R13
    end
    if (row_held || state_r == `DSPD_ST_REF) begin
      ras_n = 1'b0; // R11
    end
    if (state_r == `DSPD_ST_COL) begin
      cas_n = ~lanes_r; // R2 R4 R13
      if (write_r && width32_r) begin
        wr_n = ~lanes_r; // R10
      end else if (write_r) begin
        wr_n = {2'h3, ~lanes_r[1:0]};
      end
    end
    if (state_r == `DSPD_ST_REF) begin
      cas_n = 4'h0; // R12
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      rsp_valid              <= 1'b0;
      rsp_rdata              <= 32'h0000_0000;
      area_select_n          <= 4'hF;
      row_strobe_n           <= 1'b1;
      {col_strobe_byte3_n, col_strobe_byte2_n,
       col_strobe_byte1_n, col_strobe_byte0_n} <= `DSPD_RST_STROBES;
      read_write             <= 1'b1;
      address_latch_strobe_n <= 1'b0;
      read_strobe_n          <= 1'b1;
      {write_strobe_byte3_n, write_strobe_byte2_n,
       write_strobe_byte1_n, write_strobe_byte0_n} <= `DSPD_RST_STROBES;
      address_bus            <= 22'h00_0000;
      data_out               <= 32'h0000_0000;
      data_oe                <= 4'h0;
    end else if (clk_en) begin
      area_select_n          <= 4'hF; // R6
      address_latch_strobe_n <= 1'b0; // R8
      row_strobe_n           <= ras_n;
      {col_strobe_byte3_n, col_strobe_byte2_n,
       col_strobe_byte1_n, col_strobe_byte0_n} <= cas_n;
      {write_strobe_byte3_n, write_strobe_byte2_n,
       write_strobe_byte1_n, write_strobe_byte0_n} <= wr_n;
      rsp_valid <= (state_r == `DSPD_ST_END);
      if (state_r == `DSPD_ST_IDLE && state_nxt == `DSPD_ST_ROW) begin
        address_bus <= req_addr;
        data_out    <= req_wdata;
        read_write  <= !req_write; // R7
      end
      if (state_r == `DSPD_ST_ROW || state_r == `DSPD_ST_COL) begin
        read_strobe_n <= write_r; // R9
        data_oe       <= write_r ? lanes_r : 4'h0; // R3 R5
      end else begin
        read_strobe_n <= 1'b1;
        data_oe       <= 4'h0;
      end
      if (state_r == `DSPD_ST_END) begin
        read_write <= 1'b1;
      end
      if (state_r == `DSPD_ST_COL && cnt_r == {`DSPD_CNT_W{1'b0}} && !write_r) begin
        rsp_rdata <= data_in;
      end
    end
  end
endmodule // dspd_pin_driver

// [sim/dspd_asserts.sv]
// Purpose: Pin rule checks for the DRAM space pin driver
// Assumes: Bound to dspd_pin_driver, single clock domain
// Notes:   clk_en is held high by the bench
`timescale 1ns/1ns
module dspd_asserts (
  input logic       core_clk,
  input logic       rst,
  input logic       req_valid,
  input logic       req_ready,
  input logic       refresh_req,
  input logic       row_held,
  input logic       rsp_valid,
  input logic [3:0] area_select_n,
  input logic       row_strobe_n,
  input logic       col_strobe_byte3_n,
  input logic       col_strobe_byte0_n,
  input logic       read_write,
  input logic       address_latch_strobe_n,
  input logic       read_strobe_n,
  input logic [3:0] data_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_sel; area_select_n == 4'hF; endproperty
  a_sel: assert property (p_sel) else $error("area select active");
  property p_lat; address_latch_strobe_n == 1'b0; endproperty
  a_lat: assert property (p_lat) else $error("latch strobe high");
  property p_ras; req_valid && req_ready |-> ##2 !row_strobe_n; endproperty
  a_ras: assert property (p_ras) else $error("row strobe late");
  property p_rsp; req_valid && req_ready |-> ##5 rsp_valid; endproperty
  a_rsp: assert property (p_rsp) else $error("no response");
  property p_dir; !read_strobe_n |-> read_write; endproperty
  a_dir: assert property (p_dir) else $error("read with write dir");
  property p_oe; read_write |-> data_oe == 4'h0; endproperty
  a_oe: assert property (p_oe) else $error("data driven on read");
  property p_seq; !col_strobe_byte0_n || !col_strobe_byte3_n |-> !row_strobe_n; endproperty
  a_seq: assert property (p_seq) else $error("column without row");
  property p_ref;
    refresh_req |-> ##[1:6] (!col_strobe_byte0_n && !col_strobe_byte3_n);
  endproperty
  a_ref: assert property (p_ref) else $error("refresh strobes missing");
  property p_held; row_held |-> ##[1:2] !row_strobe_n; endproperty
  a_held: assert property (p_held) else $error("row not held");
  c_acc: cover property (req_valid && req_ready ##5 rsp_valid);
  c_wr: cover property (!read_write && !col_strobe_byte3_n);
  c_ref: cover property (refresh_req ##1 !col_strobe_byte0_n);
endmodule // dspd_asserts

// [sim/dspd_dram_model.sv]
// Purpose: Behavioural external DRAM on the data lanes
// Assumes: Word index from address bits 5..2
// Notes:   Released data lines show the inverse of the last read
`timescale 1ns/1ns
module dspd_dram_model (
  input  logic        clk,
  input  logic [3:0]  cas_n,
  input  logic        rd_n,
  input  logic        rw,
  input  logic [21:0] a,
  input  logic [31:0] d_wr,
  output logic [31:0] d_rd
);
  logic [31:0] mem [0:15];
  logic [31:0] last = 32'h0;
  wire         rd_on = !(&cas_n) && !rd_n;
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++)
      if (!cas_n[i] && !rw) mem[a[5:2]][8*i +: 8] <= d_wr[8*i +: 8];
    if (rd_on) last <= mem[a[5:2]];
  end
  assign d_rd = rd_on ? mem[a[5:2]] : ~last;
endmodule // dspd_dram_model

// [sim/tb.sv]
// Purpose: Self-checking bench for the DRAM space pin driver
// Assumes: 20 MHz clock, synchronous reset
// Notes:   Strobes are accumulated over each access
`timescale 1ns/1ns
module tb;
  logic        core_clk = 0, rst = 1, clk_en = 1, req_valid = 0, req_write = 0;
  logic        refresh_req = 0, row_held = 0;
  logic [1:0]  req_width = 0, req_size = 0;
  logic [21:0] req_addr = 0, address_bus;
  logic [31:0] req_wdata = 0, data_in, data_out, rsp_rdata;
  logic [3:0]  area_select_n, data_oe;
  logic        req_ready, rsp_valid, row_strobe_n, read_write, address_latch_strobe_n;
  logic        read_strobe_n, col_strobe_byte3_n, col_strobe_byte2_n, col_strobe_byte1_n;
  logic        col_strobe_byte0_n, write_strobe_byte3_n, write_strobe_byte2_n;
  logic        write_strobe_byte1_n, write_strobe_byte0_n;
  int          failures = 0, checks = 0, cyc = 0;
  wire [3:0]   col_n = {col_strobe_byte3_n, col_strobe_byte2_n, col_strobe_byte1_n,
                        col_strobe_byte0_n};
  wire [3:0]   wr_n = {write_strobe_byte3_n, write_strobe_byte2_n, write_strobe_byte1_n,
                       write_strobe_byte0_n};
  dspd_pin_driver i_dut (.*);
  dspd_dram_model i_mem (.clk(core_clk), .cas_n(col_n), .rd_n(read_strobe_n),
                         .rw(read_write), .a(address_bus), .d_wr(data_out), .d_rd(data_in));
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc > 3000) begin
    failures++;
    finish_test;
  end
  task automatic chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [3:0] lanes(input logic [1:0] wd, sz, a);
    if (wd == 2'h0) return 4'h1;
    if (wd == 2'h1) return sz == 2'h1 ? 4'h3 : (a[0] ? 4'h1 : 4'h2);
    if (sz == 2'h0) return 4'h8 >> a;
    if (sz == 2'h1) return a[1] ? 4'h3 : 4'hC;
    return 4'hF;
  endfunction
  // ==========================================================
  // Scenarios
  task automatic access(input logic w, input logic [1:0] wd, sz, input logic [21:0] a,
                        input logic [31:0] d);
    logic [3:0] cs, ws, oe, e;
    logic       rl, rd, ra;
    logic [31:0] m;
    int         n;
    {cs, ws, oe, rl, rd, ra} = 0;
    n = 0;
    e = lanes(wd, sz, a[1:0]);
    @(posedge core_clk);
    req_valid <= 1;
    {req_write, req_width, req_size, req_addr, req_wdata} <= {w, wd, sz, a, d};
    do @(posedge core_clk); while (req_ready !== 1'b1 && ++n < 20);
    req_valid <= 0;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      cs |= ~col_n;
      ws |= ~wr_n;
      oe |= data_oe;
      rl |= !read_write;
      rd |= !read_strobe_n;
      ra |= !row_strobe_n;
    end while (rsp_valid !== 1'b1 && ++n < 8);
    m = {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}};
    chk(rsp_valid, 1'b1);
    chk(address_bus, a);
    if (w) chk(data_out & m, d & m);
    chk(ra, 1'b1);
    chk(cs, e);
    chk(oe, w ? e : 4'h0);
    chk(ws, w ? (wd == 2'h2 ? e : e & 4'h3) : 4'h0);
    chk(rl, w);
    chk(rd, !w);
  endtask
  task automatic t_reset;
    @(posedge core_clk);
    #1;
    chk(area_select_n, 4'hF);
    chk({row_strobe_n, col_n, wr_n}, 9'h1FF);
    chk(address_latch_strobe_n, 1'b0);
  endtask
  task automatic t_table;
    for (int w = 0; w < 3; w++)
      for (int s = 0; s < 3; s++)
        for (int a = 0; a < 4; a++) begin
          if (s > w || (s == 1 && a % 2 == 1) || (s == 2 && a != 0)) continue;
          access(1'b1, w[1:0], s[1:0], 22'(a), 32'h5A3C_96E1);
          access(1'b0, w[1:0], s[1:0], 22'(a), 32'h0);
        end
  endtask
  task automatic t_round;
    access(1'b1, 2'h2, 2'h2, 22'h10, 32'hA5C3_1E69);
    access(1'b0, 2'h2, 2'h2, 22'h10, 32'h0);
    chk(rsp_rdata, 32'hA5C3_1E69);
  endtask
  task automatic t_refresh;
    int n;
    n = 0;
    @(posedge core_clk);
    refresh_req <= 1;
    do begin
      @(posedge core_clk);
      #1;
    end while (col_n !== 4'h0 && ++n < 10);
    chk(col_n, 4'h0);
    chk(row_strobe_n, 1'b0);
    @(posedge core_clk);
    refresh_req <= 0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic t_held;
    @(posedge core_clk);
    row_held <= 1;
    repeat (2) @(posedge core_clk);
    #1;
    chk(row_strobe_n, 1'b0);
    @(posedge core_clk);
    row_held <= 0;
    repeat (3) @(posedge core_clk);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_table;
    t_round;
    t_refresh;
    t_held;
    finish_test;
  end
endmodule // tb
bind dspd_pin_driver dspd_asserts i_chk (.*);
